// File: adc_ctrl_defs.svh
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
// Calibration control register: index, command bit, reset value.
`define CAL_REG_ADDR      4'h0
`define CAL_REG_CMD_BIT   15
`define CAL_REG_RESET     16'h0000
`define CAL_REG_DONE_BIT  0
// Calibration pin sequence, in clock cycles.
`define CAL_LOW_CYCLES    1280
`define CAL_HIGH_CYCLES   1280
// Calibration length and power-up delays, in clock cycles.
`define CAL_RUN_CYCLES    1400000
`define PWRUP_DLY_SHORT   67108864
`define PWRUP_DLY_LONG    64'd4294967296
// Output code extremes.
`define CODE_ALL_ZERO     7'h00
`define CODE_ALL_ONE      7'h7f
// Pipeline latency of the output path, in clock cycles.
`define PIPE_LATENCY      13
`endif

// File: adc_ctrl_pkg.sv
package adc_ctrl_pkg;
   typedef enum logic [2:0] {
      CAL_WAIT_PWR = 3'b000,
      CAL_DELAY    = 3'b001,
      CAL_HOLD     = 3'b010,
      CAL_RUN      = 3'b011,
      CAL_IDLE     = 3'b100
   } cal_state_t;

   typedef struct packed {
      logic [6:0] i_word;
      logic [6:0] q_word;
      logic       i_lo;
      logic       i_hi;
      logic       q_lo;
      logic       q_hi;
   } sample_t;

   typedef struct packed {
      logic [6:0] i_data_bus;
      logic [6:0] i_data_bus_d;
      logic [6:0] q_data_bus;
      logic [6:0] q_data_bus_d;
      logic       out_of_range;
   } out_word_t;
endpackage

// File: cal_seq_detect.sv
`timescale 1ns/100ps
`include "adc_ctrl_defs.svh"
// Detects a held-low then held-high sequence on the calibrate pin.
module cal_seq_detect #(
   parameter int LOW_CYCLES  = `CAL_LOW_CYCLES,
   parameter int HIGH_CYCLES = `CAL_HIGH_CYCLES
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic cal_pin_i,
   output logic      seq_ok_o
);
   logic [1:0]  sync_ff;
   logic [11:0] cnt_ff;
   logic [11:0] nxt_cnt;
   logic        low_met_ff;
   logic        nxt_low_met;
   logic        nxt_ok;
   logic        pin;

   assign pin = sync_ff[1];

   always_comb begin
      nxt_cnt     = cnt_ff;
      nxt_low_met = low_met_ff;
      nxt_ok      = 1'b0;
      if (!pin) begin
         nxt_ok = 1'b0;
         if (low_met_ff) begin
            nxt_cnt = 12'h000;
         end else if (cnt_ff == 12'(LOW_CYCLES - 1)) begin
            nxt_low_met = 1'b1;
            nxt_cnt     = 12'h000;
         end else begin
            nxt_cnt = cnt_ff + 12'h001;
         end
      end else if (low_met_ff) begin
         if (cnt_ff == 12'(HIGH_CYCLES - 1)) begin
            nxt_ok      = 1'b1;
            nxt_low_met = 1'b0;
            nxt_cnt     = 12'h000;
         end else begin
            nxt_cnt = cnt_ff + 12'h001;
         end
      end else begin
         nxt_cnt = 12'h000;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_ff    <= 2'h0;
         cnt_ff     <= 12'h000;
         low_met_ff <= 1'b0;
         seq_ok_o   <= 1'b0;
      end else begin
         sync_ff    <= {sync_ff[0], cal_pin_i};
         cnt_ff     <= nxt_cnt;
         low_met_ff <= nxt_low_met;
         seq_ok_o   <= nxt_ok;
      end
   end
endmodule

// File: adc_ctrl.sv
`timescale 1ns/100ps
`include "adc_ctrl_defs.svh"
// Summary of operation
// - After reset the block runs a calibration on its own once the delay expires.
// - A pin calibration needs the pin low for the low count then high for the high count.
// - Writing bit 15 of register 0 also requests a calibration.
// - A calibrate pin high at power-up suppresses the power-up calibration until a full pin sequence.
// - The delay select input chooses the short or long power-up delay count.
// - While the power-down pin is high the delay counter is held at zero and counts again from zero once low.
// - No calibration starts or continues in power-down.
// - Below negative full scale the word is all zeros, above positive full scale all ones.
// - One out-of-range output flags either channel beyond full scale.
// - With the Q channel powered down the out-of-range flag follows I only.
// - In 1:2 demux each converter drives two buses at half rate.
// - In non-demux mode the I and Q buses update every sample clock.
// - In non-demux mode a new word each clock lags its sample by a fixed pipeline latency.
// - Output drive level is normal or reduced on request.
module adc_ctrl #(
   parameter longint DLY_SHORT = `PWRUP_DLY_SHORT,
   parameter longint DLY_LONG  = `PWRUP_DLY_LONG,
   parameter int     CAL_RUN   = `CAL_RUN_CYCLES,
   parameter int     LATENCY   = `PIPE_LATENCY
) (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 cal_pin_i,
   input  wire logic                 power_up_delay_select_i,
   input  wire logic                 power_down_pin_i,
   input  wire logic                 q_channel_power_down_i,
   input  wire logic                 demux_mode_i,
   input  wire logic                 reduced_drive_i,
   input  wire logic                 reg_wr_i,
   input  wire logic [3:0]           reg_addr_i,
   input  wire logic [15:0]          reg_wdata_i,
   input  wire adc_ctrl_pkg::sample_t sample_i,
   output logic [15:0]               reg_rdata_o,
   output logic                      cal_running_o,
   output logic                      reduced_drive_o,
   output adc_ctrl_pkg::out_word_t   out_o
);
   // Link clock domain inputs are synchronised before use.
   logic [1:0] pd_sync_ff;
   logic [1:0] dsel_sync_ff;
   logic [1:0] qpd_sync_ff;
   logic [1:0] dmx_sync_ff;
   logic [1:0] red_sync_ff;
   logic [1:0] calp_sync_ff;
   logic       pd;
   logic       pin_seq_ok;
   logic       reg_cmd;
   logic       cal_req;

   adc_ctrl_pkg::cal_state_t state_ff;
   adc_ctrl_pkg::cal_state_t nxt_state;
   logic [32:0] dly_cnt_ff;
   logic [32:0] nxt_dly_cnt;
   logic [20:0] run_cnt_ff;
   logic [20:0] nxt_run_cnt;
   logic        strap_ff;
   logic        nxt_strap;
   logic        done_ff;
   logic        nxt_done;
   logic [32:0] dly_target;

   assign pd = pd_sync_ff[1];

   cal_seq_detect u_seq (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .cal_pin_i (cal_pin_i),
      .seq_ok_o  (pin_seq_ok)
   );

   assign reg_cmd = reg_wr_i && (reg_addr_i == `CAL_REG_ADDR)
                    && reg_wdata_i[`CAL_REG_CMD_BIT];
   assign cal_req = pin_seq_ok || reg_cmd;
   // The long delay needs 33 bits, so the counter is that wide.
   assign dly_target = dsel_sync_ff[1] ? 33'(DLY_LONG - 1)
                                       : 33'(DLY_SHORT - 1);

   always_comb begin
      nxt_state   = state_ff;
      nxt_dly_cnt = dly_cnt_ff;
      nxt_run_cnt = run_cnt_ff;
      nxt_strap   = strap_ff;
      nxt_done    = done_ff;
      if (reg_cmd) begin
         nxt_done = 1'b0;
      end
      unique case (state_ff)
         adc_ctrl_pkg::CAL_WAIT_PWR: begin
            // Strap the pin only after two edges, when its synchroniser holds it.
            nxt_dly_cnt = dly_cnt_ff + 33'h1;
            if (dly_cnt_ff == 33'h2) begin
               nxt_strap   = calp_sync_ff[1];
               nxt_dly_cnt = 33'h0;
               nxt_state   = adc_ctrl_pkg::CAL_DELAY;
            end
         end
         adc_ctrl_pkg::CAL_DELAY: begin
            if (pd) begin
               nxt_dly_cnt = 33'h0;
            end else if (dly_cnt_ff == dly_target) begin
               nxt_state = strap_ff ? adc_ctrl_pkg::CAL_HOLD
                                    : adc_ctrl_pkg::CAL_RUN;
               nxt_run_cnt = 21'h0;
            end else begin
               nxt_dly_cnt = dly_cnt_ff + 33'h1;
            end
         end
         adc_ctrl_pkg::CAL_HOLD: begin
            if (pin_seq_ok && !pd) begin
               nxt_state = adc_ctrl_pkg::CAL_RUN;
               nxt_run_cnt = 21'h0;
            end
         end
         adc_ctrl_pkg::CAL_RUN: begin
            if (pd) begin
               nxt_state = adc_ctrl_pkg::CAL_IDLE;
            end else if (run_cnt_ff == 21'(CAL_RUN - 1)) begin
               nxt_state = adc_ctrl_pkg::CAL_IDLE;
               nxt_done  = 1'b1;
            end else begin
               nxt_run_cnt = run_cnt_ff + 21'h1;
            end
         end
         adc_ctrl_pkg::CAL_IDLE: begin
            if (cal_req && !pd) begin
               nxt_state   = adc_ctrl_pkg::CAL_RUN;
               nxt_run_cnt = 21'h0;
               nxt_done    = 1'b0;
            end
         end
         default: nxt_state = adc_ctrl_pkg::CAL_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff   <= adc_ctrl_pkg::CAL_WAIT_PWR;
         dly_cnt_ff <= 33'h0;
         run_cnt_ff <= 21'h0;
         strap_ff   <= 1'b0;
         done_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         dly_cnt_ff <= nxt_dly_cnt;
         run_cnt_ff <= nxt_run_cnt;
         strap_ff   <= nxt_strap;
         done_ff    <= nxt_done;
      end
   end

   // Output data path: clamp, flag, latency pipeline and demux.
   logic [6:0] i_code;
   logic [6:0] q_code;
   logic       oor;
   adc_ctrl_pkg::out_word_t pipe_ff [LATENCY];
   adc_ctrl_pkg::out_word_t nxt_head;
   adc_ctrl_pkg::out_word_t nxt_out;
   logic       phase_ff;
   logic       nxt_phase;

   always_comb begin
      i_code = sample_i.i_lo ? `CODE_ALL_ZERO :
               sample_i.i_hi ? `CODE_ALL_ONE : sample_i.i_word;
      q_code = sample_i.q_lo ? `CODE_ALL_ZERO :
               sample_i.q_hi ? `CODE_ALL_ONE : sample_i.q_word;
      oor = sample_i.i_lo || sample_i.i_hi ||
            (!qpd_sync_ff[1] && (sample_i.q_lo || sample_i.q_hi));
      nxt_head = '{i_data_bus: i_code, i_data_bus_d: 7'h00,
                   q_data_bus: q_code, q_data_bus_d: 7'h00,
                   out_of_range: oor};
      nxt_phase = dmx_sync_ff[1] ? ~phase_ff : 1'b0;
      nxt_out   = pipe_ff[LATENCY-1];
      if (dmx_sync_ff[1]) begin
         // Each bus pair loads on alternate clocks, holding for two.
         nxt_out = out_o;
         if (phase_ff) begin
            nxt_out.i_data_bus   = pipe_ff[LATENCY-2].i_data_bus;
            nxt_out.q_data_bus   = pipe_ff[LATENCY-2].q_data_bus;
            nxt_out.i_data_bus_d = pipe_ff[LATENCY-1].i_data_bus;
            nxt_out.q_data_bus_d = pipe_ff[LATENCY-1].q_data_bus;
         end
         nxt_out.out_of_range = pipe_ff[LATENCY-1].out_of_range;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int k = 0; k < LATENCY; k++) begin
            pipe_ff[k] <= '0;
         end
         out_o           <= '0;
         phase_ff        <= 1'b0;
         pd_sync_ff      <= 2'h0;
         dsel_sync_ff    <= 2'h0;
         qpd_sync_ff     <= 2'h0;
         dmx_sync_ff     <= 2'h0;
         red_sync_ff     <= 2'h0;
         calp_sync_ff    <= 2'h0;
         reg_rdata_o     <= `CAL_REG_RESET;
         cal_running_o   <= 1'b0;
         reduced_drive_o <= 1'b0;
      end else begin
         pipe_ff[0] <= nxt_head;
         for (int k = 1; k < LATENCY; k++) begin
            pipe_ff[k] <= pipe_ff[k-1];
         end
         out_o           <= nxt_out;
         phase_ff        <= nxt_phase;
         pd_sync_ff      <= {pd_sync_ff[0], power_down_pin_i};
         dsel_sync_ff    <= {dsel_sync_ff[0], power_up_delay_select_i};
         qpd_sync_ff     <= {qpd_sync_ff[0], q_channel_power_down_i};
         dmx_sync_ff     <= {dmx_sync_ff[0], demux_mode_i};
         red_sync_ff     <= {red_sync_ff[0], reduced_drive_i};
         calp_sync_ff    <= {calp_sync_ff[0], cal_pin_i};
         reg_rdata_o     <= {(nxt_state == adc_ctrl_pkg::CAL_RUN),
                             14'h0, nxt_done};
         cal_running_o   <= (nxt_state == adc_ctrl_pkg::CAL_RUN);
         reduced_drive_o <= red_sync_ff[1];
      end
   end

   property p_pd_stops_cal;
      @(posedge ref_clk_i) disable iff (rst_i)
      (pd && state_ff == adc_ctrl_pkg::CAL_RUN) |=> !cal_running_o;
   endproperty
   a_pd_stops_cal: assert property (p_pd_stops_cal)
      else $error("calibration continued in power-down");

   property p_delay_holds;
      @(posedge ref_clk_i) disable iff (rst_i)
      (pd && state_ff == adc_ctrl_pkg::CAL_DELAY) |=> dly_cnt_ff == 33'h0;
   endproperty
   a_delay_holds: assert property (p_delay_holds)
      else $error("delay counter ran during power-down");

   property p_ignore_busy;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state_ff == adc_ctrl_pkg::CAL_RUN && !pd && run_cnt_ff != 21'h0
       && run_cnt_ff != 21'(CAL_RUN - 1))
      |=> run_cnt_ff == $past(run_cnt_ff) + 21'h1;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("calibration restarted while busy");

   property p_reg_cmd;
      @(posedge ref_clk_i) disable iff (rst_i)
      (reg_cmd && !pd && state_ff == adc_ctrl_pkg::CAL_IDLE)
      |=> state_ff == adc_ctrl_pkg::CAL_RUN ##1 cal_running_o;
   endproperty
   a_reg_cmd: assert property (p_reg_cmd)
      else $error("register command did not start calibration");

   property p_hold_strap;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state_ff == adc_ctrl_pkg::CAL_HOLD && !pin_seq_ok)
      |=> state_ff == adc_ctrl_pkg::CAL_HOLD;
   endproperty
   a_hold_strap: assert property (p_hold_strap)
      else $error("power-up calibration ran without pin sequence");

   property p_oor;
      @(posedge ref_clk_i) disable iff (rst_i)
      (sample_i.i_lo || sample_i.i_hi) |=> pipe_ff[0].out_of_range;
   endproperty
   a_oor: assert property (p_oor)
      else $error("out of range not flagged");

   property p_clamp;
      @(posedge ref_clk_i) disable iff (rst_i)
      sample_i.i_hi && !sample_i.i_lo
      |=> pipe_ff[0].i_data_bus == `CODE_ALL_ONE;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("over-range word not all ones");

   property p_latency;
      @(posedge ref_clk_i) disable iff (rst_i)
      (!dmx_sync_ff[1] && $stable(dmx_sync_ff[1]))
      |=> out_o.i_data_bus == $past(pipe_ff[LATENCY-1].i_data_bus);
   endproperty
   a_latency: assert property (p_latency)
      else $error("pipeline output mismatch");

   c_cal_run:  cover property (@(posedge ref_clk_i)
                  state_ff == adc_ctrl_pkg::CAL_RUN ##1
                  state_ff == adc_ctrl_pkg::CAL_IDLE);
   c_hold:     cover property (@(posedge ref_clk_i)
                  state_ff == adc_ctrl_pkg::CAL_HOLD);
   c_oor:      cover property (@(posedge ref_clk_i) out_o.out_of_range);
endmodule

// File: out_capture.sv
`timescale 1ns/100ps
// Receiving logic: latches every word one edge after the converter shows it.
module out_capture (
   input  wire logic                    ref_clk_i,
   input  wire adc_ctrl_pkg::out_word_t out_i,
   output adc_ctrl_pkg::out_word_t      word_o
);
   // The receiver has no way to stall the converter, so it never pushes back.
   always_ff @(posedge ref_clk_i) begin
      word_o <= out_i;
   end
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
   localparam int LAT = 13;
   logic                    ref_clk_i, rst_i, pin, dly, pd, q_channel_power_down, dmx, rdrv;
   logic                    wr, rdrv_o, cal;
   logic [3:0]              addr;
   logic [15:0]             wdata, rdata;
   logic [6:0]              prv;
   adc_ctrl_pkg::sample_t   smp;
   adc_ctrl_pkg::out_word_t ow, cw;
   int                      n_mismatch, n_compared, n, ch;

   adc_ctrl #(.DLY_SHORT(50), .DLY_LONG(100), .CAL_RUN(40),
              .LATENCY(LAT)) DUT (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cal_pin_i(pin),
      .power_up_delay_select_i(dly), .power_down_pin_i(pd),
      .q_channel_power_down_i(q_channel_power_down), .demux_mode_i(dmx),
      .reduced_drive_i(rdrv), .reg_wr_i(wr), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .sample_i(smp), .reg_rdata_o(rdata),
      .cal_running_o(cal), .reduced_drive_o(rdrv_o), .out_o(ow));
   out_capture rx (.ref_clk_i(ref_clk_i), .out_i(ow), .word_o(cw));

   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk_v(input logic [15:0] a, input logic [15:0] e);
      n_compared++;
      if (a !== e) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, a, e);
      end
   endtask
   task automatic chk_n(input int a, input int lo, input int hi);
      n_compared++;
      if (a < lo || a > hi) begin
         n_mismatch++;
         $display("MISMATCH at %0t: count %0d not in %0d..%0d",
                  $time, a, lo, hi);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk_i);
   endtask
   task automatic chk_idle;
      @(negedge ref_clk_i);
      chk_v(cal, 16'h0000);
   endtask
   // Counts falling edges, so the registered flag has settled when read.
   task automatic wait_cal(input logic lvl, input int mx);
      n = 0;
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (cal !== lvl && n < mx);
   endtask
   task automatic do_reset(input logic p, input logic d);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      pin   <= p;
      dly   <= d;
      tick(3);
      rst_i <= 1'b0;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr    <= 1'b0;
   endtask
   task automatic pin_seq(input int lo);
      @(posedge ref_clk_i);
      pin <= 1'b0;
      tick(lo);
      pin <= 1'b1;
      tick(1279);
   endtask
   task automatic stream(input int k);
      for (int j = 0; j < k; j++) begin
         @(posedge ref_clk_i);
         smp <= '{i_word: 7'(j + 16), q_word: 7'(j + 40), default: 1'b0};
      end
   endtask
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      tick(30000);
      n_mismatch++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      complete_run();
   end

   initial begin
      rst_i      = 1'b1;
      pin        = 1'b0;
      dly        = 1'b0;
      pd         = 1'b1;
      q_channel_power_down        = 1'b0;
      dmx        = 1'b0;
      rdrv       = 1'b0;
      wr         = 1'b0;
      addr       = 4'h0;
      wdata      = 16'h0000;
      smp        = '0;
      n_mismatch = 0;
      n_compared = 0;
      do_reset(1'b0, 1'b0);
      tick(200);
      chk_idle();
      @(posedge ref_clk_i);
      pd <= 1'b0;
      wait_cal(1'b1, 200);
      chk_n(n, 50, 62);
      wait_cal(1'b0, 100);
      chk_n(n, 39, 41);
      chk_v(rdata, 16'h0001);
      do_reset(1'b0, 1'b1);
      wait_cal(1'b1, 300);
      chk_n(n, 100, 112);
      wait_cal(1'b0, 100);
      reg_write(4'h1, 16'h8000);
      tick(10);
      chk_idle();
      reg_write(4'h0, 16'h8000);
      wait_cal(1'b1, 6);
      chk_n(n, 1, 3);
      tick(2);
      @(negedge ref_clk_i);
      chk_v(rdata[15], 16'h0001);
      reg_write(4'h0, 16'h8000);
      wait_cal(1'b0, 60);
      chk_n(n, 35, 37);
      reg_write(4'h0, 16'h8000);
      wait_cal(1'b1, 6);
      @(posedge ref_clk_i);
      pd <= 1'b1;
      wait_cal(1'b0, 8);
      chk_n(n, 1, 6);
      reg_write(4'h0, 16'h8000);
      @(posedge ref_clk_i);
      pd <= 1'b0;
      tick(10);
      chk_idle();
      pin_seq(1280);
      chk_idle();
      wait_cal(1'b1, 12);
      chk_n(n, 1, 8);
      wait_cal(1'b0, 60);
      pin_seq(100);
      tick(10);
      chk_idle();
      do_reset(1'b1, 1'b0);
      tick(150);
      chk_idle();
      pin_seq(1280);
      wait_cal(1'b1, 12);
      chk_n(n, 1, 8);
      wait_cal(1'b0, 60);
      fork
         stream(40);
         begin
            n = 0;
            do begin
               @(negedge ref_clk_i);
               n++;
            end while (cw.i_data_bus !== 7'h10 && n < 30);
            chk_n(n, LAT + 1, LAT + 4);
            for (int j = 1; j < 20; j++) begin
               @(negedge ref_clk_i);
               chk_v(cw.i_data_bus, 7'(j + 16));
               chk_v(cw.q_data_bus, 7'(j + 40));
            end
         end
      join
      for (int m = 0; m < 32; m++) begin
         @(posedge ref_clk_i);
         q_channel_power_down <= m[4];
         smp <= '{i_word: 7'h2a, q_word: 7'h35, i_lo: m[3],
                  i_hi: m[2] & ~m[3], q_lo: m[1], q_hi: m[0] & ~m[1]};
         tick(LAT + 6);
         @(negedge ref_clk_i);
         chk_v(cw.out_of_range,
               m[3] | m[2] | (~m[4] & (m[1] | m[0])));
         chk_v(cw.i_data_bus,
               m[3] ? 7'h00 : (m[2] ? 7'h7f : 7'h2a));
      end
      @(posedge ref_clk_i);
      dmx <= 1'b1;
      fork
         stream(60);
         begin
            tick(LAT + 12);
            @(negedge ref_clk_i);
            ch  = 0;
            prv = cw.i_data_bus;
            for (int j = 0; j < 16; j++) begin
               @(negedge ref_clk_i);
               if (cw.i_data_bus !== prv) begin
                  ch++;
               end
               prv = cw.i_data_bus;
               chk_v(cw.i_data_bus_d, cw.i_data_bus - 7'h01);
               chk_v(cw.q_data_bus_d, cw.q_data_bus - 7'h01);
            end
            chk_n(ch, 8, 8);
         end
      join
      chk_v(rdrv_o, 16'h0000);
      @(posedge ref_clk_i);
      rdrv <= 1'b1;
      tick(5);
      @(negedge ref_clk_i);
      chk_v(rdrv_o, 16'h0001);
      complete_run();
   end
endmodule
